/* inc/ctp_pkg.sv */
// Package with register layout, modes and carrier types of the priority control block.
package ctp_pkg;

  localparam int           CTP_LVL_W          = 3;
  localparam logic [3:0]   CTP_ADDR_PRIO_REG  = 4'h0;
  localparam logic [3:0]   CTP_ADDR_MODE_REG  = 4'h1;
  localparam logic [3:0]   CTP_ADDR_STATUS    = 4'h2;
  localparam int           CTP_BIT_ENABLE     = 7;
  localparam int           CTP_POS_XFER_LVL   = 4;
  localparam int           CTP_BIT_AUTO       = 3;
  localparam int           CTP_POS_CPU_LVL    = 0;
  localparam logic [7:0]   CTP_PRIO_RESET     = 8'h00;
  localparam logic [1:0]   CTP_MODE_RESET     = 2'h0;
  localparam logic [1:0]   CTP_MODE_SINGLE    = 2'h0;
  localparam logic [1:0]   CTP_MODE_EXTENDED  = 2'h2;
  localparam logic [2:0]   CTP_LVL_MIN        = 3'h0;
  localparam logic [2:0]   CTP_LVL_MAX        = 3'h7;

  typedef struct packed {
    logic       enable;
    logic [2:0] xfer_lvl;
    logic       auto_en;
    logic [2:0] cpu_lvl;
  } ctp_prio_reg_type;

  typedef struct packed {
    logic       cond_mask;
    logic [2:0] ext_mask;
    logic [1:0] mode;
  } ctp_mask_type;

  typedef struct packed {
    logic       cpu_wants;
    logic       xfer_req;
    logic       dma_req;
    logic [2:0] dma_lvl;
  } ctp_req_type;

  typedef struct packed {
    logic cpu_first;
    logic xfer_grant;
    logic dma_grant;
  } ctp_grant_type;

endpackage

/* rtl/ctp_level_cmp.sv */
// Compares one requester level against the CPU level and decides a grant.
`timescale 1ns/1ps
module ctp_level_cmp
  import ctp_pkg::*;
#(
  parameter int LVL_W = 3
) (
  input  wire logic             req_i,
  input  wire logic             enable_i,
  input  wire logic             cpu_wants_i,
  input  wire logic [LVL_W-1:0] req_lvl_i,
  input  wire logic [LVL_W-1:0] cpu_lvl_i,
  output logic                  grant_o,
  output logic                  cpu_wins_o
);

  // Ties go to the transfer so that a stream at the CPU level is never starved.
  always_comb begin
    cpu_wins_o = enable_i && cpu_wants_i && req_i && (req_lvl_i < cpu_lvl_i);
    grant_o    = req_i && !cpu_wins_o;
  end

endmodule

/* rtl/ctp_arbiter.sv */
// Priority control between CPU exception handling and the two transfer engines.
`timescale 1ns/1ps
module ctp_arbiter
  import ctp_pkg::*;
#(
  parameter int LVL_W = CTP_LVL_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [3:0]    addr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [7:0]    rdata_o,
  input  wire ctp_mask_type  mask_i,
  input  wire ctp_req_type   req_i,
  output ctp_grant_type      grant_o,
  output logic [LVL_W-1:0]   cpu_lvl_o
);

  ctp_prio_reg_type prio_ff;
  ctp_prio_reg_type nxt_prio;
  logic [1:0]       mode_ff;
  logic [1:0]       nxt_mode;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  logic [2:0]       mask_lvl;
  logic             xfer_grant;
  logic             dma_grant;
  logic             xfer_cpu;
  logic             dma_cpu;

  // The mode prohibited codes fall back to the single mask bit.
  always_comb begin
    if (mode_ff == CTP_MODE_EXTENDED) begin
      mask_lvl = mask_i.ext_mask;
    end else begin
      mask_lvl = mask_i.cond_mask ? CTP_LVL_MAX : CTP_LVL_MIN;
    end
  end

  always_comb begin
    nxt_prio = prio_ff;
    nxt_mode = mode_ff;
    if (wr_i && addr_i == CTP_ADDR_PRIO_REG) begin
      nxt_prio.enable   = wdata_i[CTP_BIT_ENABLE];
      nxt_prio.xfer_lvl = wdata_i[CTP_POS_XFER_LVL +: 3];
      nxt_prio.auto_en  = wdata_i[CTP_BIT_AUTO];
      if (!prio_ff.auto_en) begin
        nxt_prio.cpu_lvl = wdata_i[CTP_POS_CPU_LVL +: 3];
      end
    end
    if (wr_i && addr_i == CTP_ADDR_MODE_REG) begin
      nxt_mode = wdata_i[1:0];
    end
    // Mask tracking starts in the cycle auto-set is seen, so a write that turns it on lands first.
    if (prio_ff.auto_en) begin
      nxt_prio.cpu_lvl = mask_lvl;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        CTP_ADDR_PRIO_REG: nxt_rdata = prio_ff;
        CTP_ADDR_MODE_REG: nxt_rdata = {6'h00, mode_ff};
        CTP_ADDR_STATUS:   nxt_rdata = {5'h00, grant_o};
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prio_ff  <= CTP_PRIO_RESET;
      mode_ff  <= CTP_MODE_RESET;
      rdata_ff <= 8'h00;
    end else begin
      prio_ff  <= nxt_prio;
      mode_ff  <= nxt_mode;
      rdata_ff <= nxt_rdata;
    end
  end

  ctp_level_cmp #(.LVL_W(LVL_W)) u_xfer_cmp (
    .req_i       (req_i.xfer_req),
    .enable_i    (prio_ff.enable),
    .cpu_wants_i (req_i.cpu_wants),
    .req_lvl_i   (prio_ff.xfer_lvl),
    .cpu_lvl_i   (prio_ff.cpu_lvl),
    .grant_o     (xfer_grant),
    .cpu_wins_o  (xfer_cpu)
  );

  ctp_level_cmp #(.LVL_W(LVL_W)) u_dma_cmp (
    .req_i       (req_i.dma_req),
    .enable_i    (prio_ff.enable),
    .cpu_wants_i (req_i.cpu_wants),
    .req_lvl_i   (req_i.dma_lvl),
    .cpu_lvl_i   (prio_ff.cpu_lvl),
    .grant_o     (dma_grant),
    .cpu_wins_o  (dma_cpu)
  );

  // Both engines may be granted together; their shared bus picks between them.
  always_comb begin
    grant_o.xfer_grant = xfer_grant;
    grant_o.dma_grant  = dma_grant;
    // The CPU goes first when nothing else asks or when it outranks every asking engine.
    grant_o.cpu_first  = req_i.cpu_wants && (xfer_cpu || !req_i.xfer_req)
                         && (dma_cpu || !req_i.dma_req);
  end

  assign rdata_o   = rdata_ff;
  assign cpu_lvl_o = prio_ff.cpu_lvl;

  // Register access steps shared by the properties below.
  sequence s_prio_write;
    wr_i && addr_i == CTP_ADDR_PRIO_REG;
  endsequence

  sequence s_manual_write;
    !prio_ff.auto_en && wr_i && addr_i == CTP_ADDR_PRIO_REG;
  endsequence

  sequence s_auto_write;
    prio_ff.auto_en && wr_i && addr_i == CTP_ADDR_PRIO_REG;
  endsequence

  sequence s_mode_write;
    wr_i && addr_i == CTP_ADDR_MODE_REG;
  endsequence

  sequence s_status_read;
    rd_i && addr_i == CTP_ADDR_STATUS;
  endsequence

  a_disabled_cpu_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !prio_ff.enable && req_i.xfer_req |-> grant_o.xfer_grant && !grant_o.cpu_first)
    else $error("CPU won while priority control was off.");

  a_defer_lower_xfer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prio_ff.enable && req_i.cpu_wants && req_i.xfer_req && prio_ff.xfer_lvl < prio_ff.cpu_lvl
    |-> !grant_o.xfer_grant)
    else $error("Lower transfer request not deferred.");

  a_grant_equal_dma: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.dma_req && req_i.dma_lvl >= prio_ff.cpu_lvl |-> grant_o.dma_grant)
    else $error("Equal or higher DMA request not granted.");

  a_cpu_first_win: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prio_ff.enable && req_i.cpu_wants && req_i.xfer_req && !req_i.dma_req
    && prio_ff.xfer_lvl < prio_ff.cpu_lvl |-> grant_o.cpu_first)
    else $error("CPU did not take precedence.");

  a_auto_ext_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prio_ff.auto_en && mode_ff == CTP_MODE_EXTENDED |=> prio_ff.cpu_lvl == $past(mask_i.ext_mask))
    else $error("CPU level did not follow extended mask.");

  a_auto_single_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prio_ff.auto_en && mode_ff == CTP_MODE_SINGLE
    |=> prio_ff.cpu_lvl == ($past(mask_i.cond_mask) ? 3'h7 : 3'h0))
    else $error("Single mask bit mapped wrongly.");

  a_manual_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !prio_ff.auto_en && !(wr_i && addr_i == CTP_ADDR_PRIO_REG) |=> $stable(prio_ff.cpu_lvl))
    else $error("CPU level changed without a write.");

  a_write_cpu_lvl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_manual_write |=> prio_ff.cpu_lvl == $past(wdata_i[2:0]))
    else $error("CPU level write lost.");

  a_write_xfer_lvl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_prio_write |=> prio_ff.xfer_lvl == $past(wdata_i[6:4]))
    else $error("Transfer level write lost.");

  a_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == CTP_ADDR_PRIO_REG |=> rdata_o == $past(prio_ff))
    else $error("Register read back wrong.");

  a_auto_drop_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_auto_write |=> prio_ff.cpu_lvl == $past(mask_lvl))
    else $error("CPU level write taken while auto-set was on.");

  a_mode_fallback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prio_ff.auto_en && mode_ff != CTP_MODE_EXTENDED
    |=> prio_ff.cpu_lvl == ($past(mask_i.cond_mask) ? CTP_LVL_MAX : CTP_LVL_MIN))
    else $error("Non-extended mode did not use the single mask bit.");

  a_mode_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_mode_write |=> mode_ff == $past(wdata_i[1:0]))
    else $error("Mode write lost.");

  a_enable_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_prio_write |=> prio_ff.enable == $past(wdata_i[CTP_BIT_ENABLE]))
    else $error("Enable write lost.");

  a_defer_lower_dma: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prio_ff.enable && req_i.cpu_wants && req_i.dma_req && req_i.dma_lvl < prio_ff.cpu_lvl
    |-> !grant_o.dma_grant)
    else $error("Lower DMA request not deferred.");

  a_status_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_status_read |=> rdata_o == {5'h00, $past(grant_o)})
    else $error("Status read back wrong.");

  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("Read data stood without a read.");

endmodule

/* tb/ctp_req_model.sv */
// Model of the transfer controller and DMA controller requesters.
`timescale 1ns/1ps
module ctp_req_model
  import ctp_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  go_i,
  output ctp_req_type req_o
);
  logic [4:0] pick;
  initial req_o = '0;
  // One engine asks at a time, so the bench never relies on an untold tie rule.
  always @(posedge clk_i) begin
    if (go_i) begin
      pick = 5'($urandom);
      // The DMA level is the controller's own channel level, not the register's.
      req_o <= '{pick[4], pick[3], !pick[3], pick[2:0]};
    end
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the priority control block.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import ctp_pkg::*;
  logic          clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, go = 0;
  logic [3:0]    addr_i = '0;
  logic [7:0]    wdata_i = '0, rdata_o, v, got;
  ctp_mask_type  mask_i = '0;
  ctp_req_type   req;
  ctp_grant_type grant_o;
  logic [2:0]    cpu_lvl_o, m;
  int            n_mismatch = 0, comparisons = 0, n;
  ctp_arbiter DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mask_i(mask_i), .req_i(req),
    .grant_o(grant_o), .cpu_lvl_o(cpu_lvl_o));
  ctp_req_model PEER (.clk_i(clk_i), .go_i(go), .req_o(req));
  initial forever #2.5 clk_i = !clk_i;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask
  function automatic ctp_grant_type exp_g(input logic [7:0] r, input ctp_req_type q);
    ctp_grant_type g;
    g.xfer_grant = q.xfer_req & (!r[7] | !q.cpu_wants | r[6:4] >= r[2:0]);
    g.dma_grant  = q.dma_req & (!r[7] | !q.cpu_wants | q.dma_lvl >= r[2:0]);
    g.cpu_first  = q.cpu_wants & !g.xfer_grant & !g.dma_grant;
    return g;
  endfunction
  task automatic finish_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100us n_mismatch++;
    finish_test();
  end
  initial begin
    n = $urandom(32'h33354F02);
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, v);
    `CHK(v, CTP_PRIO_RESET)
    rd(4'hF, v);
    `CHK(v, 8'h00)
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom) & 8'hF7;
      wr(4'h0, v);
      rd(4'h0, got);
      `CHK(got, v)
      `CHK(cpu_lvl_o, v[2:0])
    end
    $display("test register done");
    for (int i = 0; i < 40; i++) begin
      v = (i == 0) ? 8'hD5 : (i == 1) ? 8'hC5 : (i == 2) ? 8'h07 : 8'($urandom) & 8'hF7;
      wr(4'h0, v);
      repeat (4) begin
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        @(negedge clk_i) `CHK(grant_o, exp_g(v, req))
        rd(4'h2, got);
        `CHK(got, {5'h00, exp_g(v, req)})
      end
    end
    $display("test grant done");
    wr(4'h1, {6'h00, CTP_MODE_EXTENDED});
    rd(4'h1, got);
    `CHK(got, {6'h00, CTP_MODE_EXTENDED})
    for (int i = 0; i < 6; i++) begin
      m = 3'($urandom);
      @(posedge clk_i) mask_i <= '{!m[0], m, 2'h1};
      wr(4'h0, 8'h88);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i) `CHK(cpu_lvl_o, m)
      wr(4'h0, {5'h11, ~m});
      rd(4'h0, v);
      `CHK(v, {5'h11, m})
    end
    wr(4'h1, {6'h00, CTP_MODE_SINGLE});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) mask_i <= '{i[0], 3'h0, 2'h2};
      repeat (2) @(posedge clk_i);
      @(negedge clk_i) `CHK(cpu_lvl_o, i[0] ? CTP_LVL_MAX : CTP_LVL_MIN)
    end
    // A prohibited mode code must behave as the single mask bit, not the extended mask.
    wr(4'h1, 8'h03);
    @(posedge clk_i) mask_i <= '{1'b0, 3'h6, 2'h2};
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) `CHK(cpu_lvl_o, CTP_LVL_MIN)
    @(posedge clk_i) mask_i <= '{1'b1, 3'h0, 2'h2};
    // The write that turns auto-set off still loses its level bits, so it is written twice.
    wr(4'h0, 8'h03);
    @(negedge clk_i) `CHK(cpu_lvl_o, CTP_LVL_MAX)
    wr(4'h0, 8'h03);
    @(posedge clk_i) mask_i <= '{1'b0, 3'h5, 2'h2};
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) `CHK(cpu_lvl_o, 3'h3)
    $display("test auto level done");
    @(posedge clk_i) rst_n_i <= 1'b0;
    @(posedge clk_i) rst_n_i <= 1'b1;
    rd(4'h0, v);
    `CHK(v, CTP_PRIO_RESET)
    rd(4'h1, v);
    `CHK(v, {6'h00, CTP_MODE_RESET})
    $display("test mid reset done");
    finish_test();
  end
endmodule
